// >>> core/gpwdt_params.svh
// Register map, reset values, field positions and time base constants
`ifndef GPWDT_PARAMS_SVH
`define GPWDT_PARAMS_SVH

// Register addresses on the microcontroller bus
`define GPWDT_ADDR_GLOBAL 16'ha03a
`define GPWDT_ADDR_WD_EN 16'ha0a0
`define GPWDT_ADDR_IV_EN 16'ha0a1
`define GPWDT_ADDR_STATUS 16'ha0a2
`define GPWDT_ADDR_IV_TC 16'ha0a3
`define GPWDT_ADDR_WD_TC 16'ha0a4
`define GPWDT_ADDR_TB 16'ha0a5
`define GPWDT_ADDR_IRQ_EN 16'ha0a6

// Field positions
`define GPWDT_BIT_RUN 0
`define GPWDT_BIT_KICK 4
`define GPWDT_BIT_IV_FLAG 0
`define GPWDT_BIT_WD_FLAG 4
`define GPWDT_BIT_GATE 0
`define GPWDT_TB_IV_LO 0
`define GPWDT_TB_WD_LO 4

// Reset values
`define GPWDT_RST_ZERO 8'h00
`define GPWDT_RST_TC 8'hff

// Time base: system clock and tick rates in hertz, 32.768 kHz rate in millihertz, periods in seconds
`define GPWDT_CLK_HZ 50000000
`define GPWDT_F_32K_MHZ 32768000
`define GPWDT_F_1024_HZ 1024
`define GPWDT_F_8_HZ 8
`define GPWDT_F_1_HZ 1
`define GPWDT_T_2S 2
`define GPWDT_T_MIN_S 60
`define GPWDT_DIV_32K ((`GPWDT_CLK_HZ * 64'd1000) / `GPWDT_F_32K_MHZ)
`define GPWDT_DIV_1024 (`GPWDT_CLK_HZ / `GPWDT_F_1024_HZ)
`define GPWDT_DIV_8 (`GPWDT_CLK_HZ / `GPWDT_F_8_HZ)
`define GPWDT_DIV_1 (`GPWDT_CLK_HZ / `GPWDT_F_1_HZ)
`define GPWDT_DIV_2S (`GPWDT_CLK_HZ * `GPWDT_T_2S)
`define GPWDT_DIV_MIN (64'd50000000 * `GPWDT_T_MIN_S)

`endif

// >>> core/gpwdt_pkg.sv
// Types shared by the timer block
package gpwdt_pkg;
  typedef logic [1:0] gpwdt_tick_sel_t;
  typedef logic [7:0] gpwdt_byte_t;
  typedef enum logic [2:0]
  {
    GPWDT_IDLE = 3'b001,
    GPWDT_COUNT = 3'b010,
    GPWDT_EXPIRE = 3'b100
  } gpwdt_state_t;
endpackage

// >>> core/gpwdt_tick_if.sv
// Tick bundle from the time base to the timers
`timescale 1ns/1ps
`default_nettype none
interface gpwdt_tick_if;
  logic tick32k;
  logic tick1024;
  logic tick8;
  logic tick1;
  logic tickHalf;
  logic tickMin;
  modport source (output tick32k, tick1024, tick8, tick1, tickHalf, tickMin);
  modport sink (input tick32k, tick1024, tick8, tick1, tickHalf, tickMin);
endinterface
`default_nettype wire

// >>> core/gpwdt_timebase.sv
// Slow tick generator, held while the timer clock is gated
`timescale 1ns/1ps
`default_nettype none
`include "gpwdt_params.svh"
module gpwdt_timebase
#(
  parameter longint DIV_32K = `GPWDT_DIV_32K,
  parameter longint DIV_1024 = `GPWDT_DIV_1024,
  parameter longint DIV_8 = `GPWDT_DIV_8,
  parameter longint DIV_1 = `GPWDT_DIV_1,
  parameter longint DIV_2S = `GPWDT_DIV_2S,
  parameter longint DIV_MIN = `GPWDT_DIV_MIN
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Gate
  input wire logic gateOn,
  // Ticks
  gpwdt_tick_if.source ticks
);
  localparam int N = 6;
  localparam longint DIVS [N] = '{DIV_32K, DIV_1024, DIV_8, DIV_1, DIV_2S, DIV_MIN};
  logic [N-1:0] pulse;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gDiv
      logic [31:0] cnt_r;
      wire logic atEnd = (cnt_r == 32'(DIVS[g] - 1));
      assign pulse[g] = gateOn && atEnd;
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
          cnt_r <= '0;
        else if (gateOn)
          cnt_r <= atEnd ? '0 : cnt_r + 32'h1;
      end
    end
  endgenerate

  assign ticks.tick32k = pulse[0];
  assign ticks.tick1024 = pulse[1];
  assign ticks.tick8 = pulse[2];
  assign ticks.tick1 = pulse[3];
  assign ticks.tickHalf = pulse[4];
  assign ticks.tickMin = pulse[5];
endmodule
`default_nettype wire

// >>> core/gpwdt_timers.sv
// Interval timer and watchdog timer with their register set
//
// Operation
// [R01] Two independent 8-bit up-counters: interval timer and watchdog, each fully separate; here both share one time base and the global gate.
// [R02] Interval tick select: 00 32.768 kHz, 01 1024 Hz, 10 1 Hz, 11 minute.
// [R03] Watchdog tick select bits 5:4: 00 8 Hz, 01 1 Hz, 10 0.5 Hz, 11 minute.
// [R04] Writing one to interval run bit counts ticks from zero up to terminal.
// [R05] Reaching interval terminal sets status bit 0.
// [R06] Interval expiry with enable bit 0 set raises the interrupt.
// [R07] Flags clear only on write of one; zero leaves them; reset zero.
// [R08] Interval expiry stops, zeroes counter, clears run; terminal and select kept.
// [R09] Writing zero to interval run while counting stops and zeroes counter.
// [R10] Writing one to watchdog run counts to terminal, then sets status bit 4.
// [R11] Watchdog expiry with enable bit 4 set raises the interrupt.
// [R12] Watchdog expiry stops, zeroes counter, clears watchdog run bit.
// [R13] Kick bit 4 zeroes watchdog count and restarts; reads as zero. Here a kick written with run bit 0 stops the watchdog and does not restart it.
// [R14] Global gate bit 0 stops timer clocking, keeps settings; reset zero.
// [R15] Each terminal count is an 8-bit read-write register, reset all ones.
// [R16] Interrupt output high while any flag and its enable are both set.
`timescale 1ns/1ps
`default_nettype none
`include "gpwdt_params.svh"
module gpwdt_timers
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Interrupt
  output logic timerIrq,
  // Observed counts
  output logic [7:0] intervalCount,
  output logic [7:0] watchdogCount
);
  // Register state
  logic timer_clock_gate_enable_r;
  logic interval_run_r, interval_run_nxt;
  logic watchdog_run_r, watchdog_run_nxt;
  logic interval_expired_flag_r, interval_expired_flag_nxt;
  logic watchdog_expired_flag_r, watchdog_expired_flag_nxt;
  gpwdt_pkg::gpwdt_byte_t interval_terminal_r;
  gpwdt_pkg::gpwdt_byte_t watchdog_terminal_r;
  gpwdt_pkg::gpwdt_tick_sel_t interval_tick_select_r;
  gpwdt_pkg::gpwdt_tick_sel_t watchdog_tick_select_r;
  logic interval_irq_enable_r;
  logic watchdog_irq_enable_r;
  logic [7:0] ivCount_r, ivCount_nxt;
  logic [7:0] wdCount_r, wdCount_nxt;
  gpwdt_pkg::gpwdt_state_t ivState_r, ivState_nxt;
  gpwdt_pkg::gpwdt_state_t wdState_r, wdState_nxt;
  logic [7:0] rdata_r;

  // Address decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire logic selGlobal = hit(regAddr, `GPWDT_ADDR_GLOBAL);
  wire logic selWdEn = hit(regAddr, `GPWDT_ADDR_WD_EN);
  wire logic selIvEn = hit(regAddr, `GPWDT_ADDR_IV_EN);
  wire logic selStatus = hit(regAddr, `GPWDT_ADDR_STATUS);
  wire logic selIvTc = hit(regAddr, `GPWDT_ADDR_IV_TC);
  wire logic selWdTc = hit(regAddr, `GPWDT_ADDR_WD_TC);
  wire logic selTb = hit(regAddr, `GPWDT_ADDR_TB);
  wire logic selIrqEn = hit(regAddr, `GPWDT_ADDR_IRQ_EN);

  wire logic wrGlobal = regWrite && selGlobal;
  wire logic wrWdEn = regWrite && selWdEn;
  wire logic wrIvEn = regWrite && selIvEn;
  wire logic wrStatus = regWrite && selStatus;
  wire logic wrIvTc = regWrite && selIvTc;
  wire logic wrWdTc = regWrite && selWdTc;
  wire logic wrTb = regWrite && selTb;
  wire logic wrIrqEn = regWrite && selIrqEn;

  // Time base
  gpwdt_tick_if tickBus ();
  gpwdt_timebase uTimebase
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .gateOn(timer_clock_gate_enable_r), // [R14]
    .ticks(tickBus.source)
  );

  // Tick selection, one decode shared by both timers
  function automatic logic pickTick(input gpwdt_pkg::gpwdt_tick_sel_t sel, input logic t0,
                                    input logic t1, input logic t2, input logic t3);
    unique case (sel)
      2'h0: pickTick = t0;
      2'h1: pickTick = t1;
      2'h2: pickTick = t2;
      2'h3: pickTick = t3;
    endcase
  endfunction

  wire logic ivTick = pickTick(interval_tick_select_r, tickBus.tick32k, tickBus.tick1024,
                               tickBus.tick1, tickBus.tickMin); // [R02]
  wire logic wdTick = pickTick(watchdog_tick_select_r, tickBus.tick8, tickBus.tick1,
                               tickBus.tickHalf, tickBus.tickMin); // [R03]

  // Written control bits
  wire logic ivRunWr = regWdata[`GPWDT_BIT_RUN];
  wire logic wdRunWr = regWdata[`GPWDT_BIT_RUN];
  wire logic kick = wrWdEn && regWdata[`GPWDT_BIT_KICK];
  wire logic ivFlagClr = wrStatus && regWdata[`GPWDT_BIT_IV_FLAG];
  wire logic wdFlagClr = wrStatus && regWdata[`GPWDT_BIT_WD_FLAG];

  // Terminal detection, counts run from zero; a gated timer cannot expire
  wire logic ivHitNow = timer_clock_gate_enable_r && (ivCount_r == interval_terminal_r); // [R14]
  wire logic wdHitNow = timer_clock_gate_enable_r && (wdCount_r == watchdog_terminal_r); // [R14]
  wire logic ivExpire = (ivState_r == gpwdt_pkg::GPWDT_EXPIRE);
  wire logic wdExpire = (wdState_r == gpwdt_pkg::GPWDT_EXPIRE);

  // Interval timer next state
  always_comb
  begin
    ivState_nxt = ivState_r;
    ivCount_nxt = ivCount_r;
    interval_run_nxt = interval_run_r;
    unique case (ivState_r)
      gpwdt_pkg::GPWDT_IDLE:
      begin
        if (wrIvEn && ivRunWr)
        begin
          interval_run_nxt = 1'b1;
          ivCount_nxt = 8'h00; // [R04]
          ivState_nxt = gpwdt_pkg::GPWDT_COUNT;
        end
      end
      gpwdt_pkg::GPWDT_COUNT:
      begin
        if (wrIvEn && !ivRunWr)
        begin
          interval_run_nxt = 1'b0;
          ivCount_nxt = 8'h00; // [R09]
          ivState_nxt = gpwdt_pkg::GPWDT_IDLE;
        end
        else if (ivHitNow)
          ivState_nxt = gpwdt_pkg::GPWDT_EXPIRE; // [R04]
        else if (ivTick)
          ivCount_nxt = ivCount_r + 8'h01; // [R01] [R04]
      end
      gpwdt_pkg::GPWDT_EXPIRE:
      begin
        interval_run_nxt = 1'b0;
        ivCount_nxt = 8'h00; // [R08]
        ivState_nxt = gpwdt_pkg::GPWDT_IDLE;
      end
      default:
      begin
        interval_run_nxt = 1'b0;
        ivCount_nxt = 8'h00;
        ivState_nxt = gpwdt_pkg::GPWDT_IDLE;
      end
    endcase
  end

  // Watchdog next state
  always_comb
  begin
    wdState_nxt = wdState_r;
    wdCount_nxt = wdCount_r;
    watchdog_run_nxt = watchdog_run_r;
    unique case (wdState_r)
      gpwdt_pkg::GPWDT_IDLE:
      begin
        if (wrWdEn && wdRunWr)
        begin
          watchdog_run_nxt = 1'b1;
          wdCount_nxt = 8'h00; // [R10]
          wdState_nxt = gpwdt_pkg::GPWDT_COUNT;
        end
      end
      gpwdt_pkg::GPWDT_COUNT:
      begin
        if (wrWdEn && !wdRunWr)
        begin
          watchdog_run_nxt = 1'b0;
          wdCount_nxt = 8'h00;
          wdState_nxt = gpwdt_pkg::GPWDT_IDLE;
        end
        else if (kick)
          wdCount_nxt = 8'h00; // [R13]
        else if (wdHitNow)
          wdState_nxt = gpwdt_pkg::GPWDT_EXPIRE; // [R10]
        else if (wdTick)
          wdCount_nxt = wdCount_r + 8'h01; // [R01] [R10]
      end
      gpwdt_pkg::GPWDT_EXPIRE:
      begin
        watchdog_run_nxt = 1'b0;
        wdCount_nxt = 8'h00; // [R12]
        wdState_nxt = gpwdt_pkg::GPWDT_IDLE;
      end
      default:
      begin
        watchdog_run_nxt = 1'b0;
        wdCount_nxt = 8'h00;
        wdState_nxt = gpwdt_pkg::GPWDT_IDLE;
      end
    endcase
  end

  // Flags: the set wins over a simultaneous clear
  assign interval_expired_flag_nxt = ivExpire ? 1'b1 :
                                     (ivFlagClr ? 1'b0 : interval_expired_flag_r); // [R05] [R07]
  assign watchdog_expired_flag_nxt = wdExpire ? 1'b1 :
                                     (wdFlagClr ? 1'b0 : watchdog_expired_flag_r); // [R10] [R07]

  // Interval timer registers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ivState_r <= gpwdt_pkg::GPWDT_IDLE;
      ivCount_r <= `GPWDT_RST_ZERO;
      interval_run_r <= 1'b0;
      interval_expired_flag_r <= 1'b0; // [R07]
    end
    else
    begin
      ivState_r <= ivState_nxt;
      ivCount_r <= ivCount_nxt;
      interval_run_r <= interval_run_nxt;
      interval_expired_flag_r <= interval_expired_flag_nxt;
    end
  end

  // Watchdog registers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wdState_r <= gpwdt_pkg::GPWDT_IDLE;
      wdCount_r <= `GPWDT_RST_ZERO;
      watchdog_run_r <= 1'b0;
      watchdog_expired_flag_r <= 1'b0; // [R07]
    end
    else
    begin
      wdState_r <= wdState_nxt;
      wdCount_r <= wdCount_nxt;
      watchdog_run_r <= watchdog_run_nxt;
      watchdog_expired_flag_r <= watchdog_expired_flag_nxt;
    end
  end

  // Clock gate
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      timer_clock_gate_enable_r <= 1'b0; // [R14]
    else if (wrGlobal)
      timer_clock_gate_enable_r <= regWdata[`GPWDT_BIT_GATE];
  end

  // Terminal counts
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      interval_terminal_r <= `GPWDT_RST_TC; // [R15]
    else if (wrIvTc)
      interval_terminal_r <= regWdata; // [R15]
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      watchdog_terminal_r <= `GPWDT_RST_TC; // [R15]
    else if (wrWdTc)
      watchdog_terminal_r <= regWdata; // [R15]
  end

  // Tick selects
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      interval_tick_select_r <= 2'h0;
      watchdog_tick_select_r <= 2'h0;
    end
    else if (wrTb)
    begin
      interval_tick_select_r <= regWdata[`GPWDT_TB_IV_LO +: 2];
      watchdog_tick_select_r <= regWdata[`GPWDT_TB_WD_LO +: 2];
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      interval_irq_enable_r <= 1'b0;
      watchdog_irq_enable_r <= 1'b0;
    end
    else if (wrIrqEn)
    begin
      interval_irq_enable_r <= regWdata[`GPWDT_BIT_IV_FLAG];
      watchdog_irq_enable_r <= regWdata[`GPWDT_BIT_WD_FLAG];
    end
  end

  // Read mux, kick bit always reads zero
  logic [7:0] rdMux;
  always_comb
  begin
    rdMux = 8'h00;
    unique case (1'b1)
      selGlobal: rdMux[`GPWDT_BIT_GATE] = timer_clock_gate_enable_r;
      selWdEn: rdMux[`GPWDT_BIT_RUN] = watchdog_run_r; // [R13]
      selIvEn: rdMux[`GPWDT_BIT_RUN] = interval_run_r;
      selStatus:
      begin
        rdMux[`GPWDT_BIT_IV_FLAG] = interval_expired_flag_r;
        rdMux[`GPWDT_BIT_WD_FLAG] = watchdog_expired_flag_r;
      end
      selIvTc: rdMux = interval_terminal_r;
      selWdTc: rdMux = watchdog_terminal_r;
      selTb:
      begin
        rdMux[`GPWDT_TB_IV_LO +: 2] = interval_tick_select_r;
        rdMux[`GPWDT_TB_WD_LO +: 2] = watchdog_tick_select_r;
      end
      selIrqEn:
      begin
        rdMux[`GPWDT_BIT_IV_FLAG] = interval_irq_enable_r;
        rdMux[`GPWDT_BIT_WD_FLAG] = watchdog_irq_enable_r;
      end
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      rdata_r <= 8'h00;
    else if (regRead)
      rdata_r <= rdMux;
  end

  // Outputs
  assign regRdata = rdata_r;
  assign timerIrq = (interval_expired_flag_r && interval_irq_enable_r) || // [R06] [R16]
                    (watchdog_expired_flag_r && watchdog_irq_enable_r); // [R11] [R16]
  assign intervalCount = ivCount_r;
  assign watchdogCount = wdCount_r;
endmodule
`default_nettype wire

// >>> testbench/gpwdt_timers_checker.sv
// Port-level assertions for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "gpwdt_params.svh"
module gpwdt_timers_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // Outputs
  input wire logic timerIrq,
  input wire logic [7:0] intervalCount,
  input wire logic [7:0] watchdogCount
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [15:0] a);
    regRead && regAddr == a;
  endsequence
  sequence s_wr(logic [15:0] a);
    regWrite && regAddr == a;
  endsequence
  property p_rw(logic [15:0] a, logic [7:0] m);
    s_wr(a) ##2 s_rd(a) |=> regRdata == ($past(regWdata, 3) & m);
  endproperty
  property p_step(logic [7:0] c);
    c != $past(c) |-> c == $past(c) + 8'h01 || c == 8'h00;
  endproperty
  a_kick_reads_zero: assert property (
    s_rd(`GPWDT_ADDR_WD_EN) |=> (regRdata & 8'hfe) == 8'h00) else $error("kick bit read back");
  a_status_bits_only: assert property (
    s_rd(`GPWDT_ADDR_STATUS) |=> (regRdata & 8'hee) == 8'h00) else $error("status spare bits");
  a_iv_stop_zero: assert property (
    s_wr(`GPWDT_ADDR_IV_EN) ##0 !regWdata[0] |=> intervalCount == 8'h00) else $error("iv stop");
  a_wd_kick_zero: assert property (
    s_wr(`GPWDT_ADDR_WD_EN) ##0 regWdata[4] |=> watchdogCount == 8'h00) else $error("wd kick");
  a_iv_count_step: assert property (p_step(intervalCount)) else $error("iv step");
  a_wd_count_step: assert property (p_step(watchdogCount)) else $error("wd step");
  a_irq_masked_off: assert property (
    s_wr(`GPWDT_ADDR_IRQ_EN) ##0 regWdata == 8'h00 |=> !timerIrq) else $error("irq masked");
  a_iv_tc_rw: assert property (p_rw(`GPWDT_ADDR_IV_TC, 8'hff)) else $error("iv tc");
  a_wd_tc_rw: assert property (p_rw(`GPWDT_ADDR_WD_TC, 8'hff)) else $error("wd tc");
  a_tick_sel_rw: assert property (p_rw(`GPWDT_ADDR_TB, 8'h33)) else $error("tick sel");
endmodule
bind gpwdt_timers gpwdt_timers_checker i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
  .regRdata(regRdata), .timerIrq(timerIrq), .intervalCount(intervalCount),
  .watchdogCount(watchdogCount));
`default_nettype wire

// >>> testbench/gpwdt_timers_tb.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "gpwdt_params.svh"
module gpwdt_timers_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic timerIrq;
  logic [7:0] intervalCount;
  logic [7:0] watchdogCount;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int t;
  logic [7:0] d;
  localparam logic [15:0] RW_ADDR [6] = '{`GPWDT_ADDR_GLOBAL, `GPWDT_ADDR_IV_TC,
    `GPWDT_ADDR_WD_TC, `GPWDT_ADDR_TB, `GPWDT_ADDR_IRQ_EN, 16'ha0a7};
  always #10 clk_sys = ~clk_sys;
  gpwdt_timers i_gpwdt_timers (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .timerIrq(timerIrq), .intervalCount(intervalCount), .watchdogCount(watchdogCount));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      results();
    end
  end
  function automatic logic [7:0] mask(input logic [15:0] a);
    case (a)
      `GPWDT_ADDR_GLOBAL: return 8'h01;
      `GPWDT_ADDR_IV_TC, `GPWDT_ADDR_WD_TC: return 8'hff;
      `GPWDT_ADDR_TB: return 8'h33;
      `GPWDT_ADDR_IRQ_EN: return 8'h11;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    regAddr = a;
    regWdata = v;
    regWrite = 1'b1;
    @(posedge clk_sys);
    #1 regWrite = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk_sys);
    #1 regRead = 1'b0;
    chk(regRdata, e);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic waitIrq(input int lim);
    n = 0;
    while (timerIrq !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(8'(n < lim), 8'h01);
  endtask
  initial
  begin
    void'($urandom(32'hbf2ac65e));
    repeat (16) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    foreach (RW_ADDR[i])
      rd(RW_ADDR[i], (mask(RW_ADDR[i]) == 8'hff) ? 8'hff : 8'h00);
    rd(`GPWDT_ADDR_STATUS, 8'h00);
    rd(`GPWDT_ADDR_WD_EN, 8'h00);
    $display("test reset done");
    repeat (4) foreach (RW_ADDR[i])
    begin
      d = 8'($urandom);
      wr(RW_ADDR[i], d);
      rd(RW_ADDR[i], d & mask(RW_ADDR[i]));
    end
    $display("test readback done");
    wr(`GPWDT_ADDR_GLOBAL, 8'h01);
    wr(`GPWDT_ADDR_TB, 8'h00);
    wr(`GPWDT_ADDR_IRQ_EN, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      t = (k < 2) ? k : $urandom_range(3, 2);
      wr(`GPWDT_ADDR_IV_TC, 8'(t));
      wr(`GPWDT_ADDR_IV_EN, 8'h01);
      waitIrq(t * 1530 + 20);
      chk(8'(n >= (t - 1) * 1525), 8'h01);
      chk(intervalCount, 8'h00);
      rd(`GPWDT_ADDR_IV_EN, 8'h00);
      rd(`GPWDT_ADDR_IV_TC, 8'(t));
      wr(`GPWDT_ADDR_STATUS, 8'h00);
      rd(`GPWDT_ADDR_STATUS, 8'h01);
      wr(`GPWDT_ADDR_STATUS, 8'h01);
      chk(8'(timerIrq), 8'h00);
    end
    $display("test interval done");
    wr(`GPWDT_ADDR_IV_TC, 8'h03);
    wr(`GPWDT_ADDR_IV_EN, 8'h01);
    n = 0;
    while (intervalCount !== 8'h01 && n < 2000)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(8'(n < 2000), 8'h01);
    wr(`GPWDT_ADDR_IV_EN, 8'h00);
    chk(intervalCount, 8'h00);
    repeat (5000) @(posedge clk_sys);
    #1 rd(`GPWDT_ADDR_STATUS, 8'h00);
    $display("test stop done");
    wr(`GPWDT_ADDR_GLOBAL, 8'h00);
    wr(`GPWDT_ADDR_IV_TC, 8'h01);
    wr(`GPWDT_ADDR_IV_EN, 8'h01);
    repeat (3200) @(posedge clk_sys);
    #1 chk(intervalCount, 8'h00);
    rd(`GPWDT_ADDR_IV_TC, 8'h01);
    wr(`GPWDT_ADDR_GLOBAL, 8'h01);
    waitIrq(1550);
    wr(`GPWDT_ADDR_STATUS, 8'h01);
    wr(`GPWDT_ADDR_GLOBAL, 8'h00);
    wr(`GPWDT_ADDR_IV_TC, 8'h00);
    wr(`GPWDT_ADDR_IV_EN, 8'h01);
    rd(`GPWDT_ADDR_STATUS, 8'h00);
    wr(`GPWDT_ADDR_GLOBAL, 8'h01);
    waitIrq(20);
    wr(`GPWDT_ADDR_STATUS, 8'h01);
    $display("test gate done");
    wr(`GPWDT_ADDR_IRQ_EN, 8'h10);
    wr(`GPWDT_ADDR_WD_TC, 8'h00);
    wr(`GPWDT_ADDR_WD_EN, 8'h01);
    waitIrq(20);
    chk(watchdogCount, 8'h00);
    rd(`GPWDT_ADDR_WD_EN, 8'h00);
    rd(`GPWDT_ADDR_STATUS, 8'h10);
    wr(`GPWDT_ADDR_IRQ_EN, 8'h01);
    chk(8'(timerIrq), 8'h00);
    wr(`GPWDT_ADDR_STATUS, 8'h10);
    rd(`GPWDT_ADDR_STATUS, 8'h00);
    wr(`GPWDT_ADDR_WD_TC, 8'h05);
    wr(`GPWDT_ADDR_WD_EN, 8'h01);
    wr(`GPWDT_ADDR_WD_EN, 8'h11);
    rd(`GPWDT_ADDR_WD_EN, 8'h01);
    chk(watchdogCount, 8'h00);
    wr(`GPWDT_ADDR_WD_EN, 8'h00);
    wr(`GPWDT_ADDR_IRQ_EN, 8'h00);
    chk(8'(timerIrq), 8'h00);
    $display("test watchdog done");
    results();
  end
endmodule
`default_nettype wire
